// [pamx_pkg.sv]
`default_nettype none

package pamx_pkg;

    // register byte offsets on the apb side
    localparam logic [11:0] PAMX_OFF_PIN_SELECT = 12'h030;
    localparam logic [11:0] PAMX_OFF_ALT_WORD   = 12'h050;
    localparam logic [11:0] PAMX_OFF_ALT_WORD1  = 12'h054;
    localparam logic [11:0] PAMX_OFF_FN_STATUS  = 12'h058;

    // reset value of every writable word
    localparam logic [31:0] PAMX_RST_WORD = 32'h0000_0000;

    // pin select word layout
    localparam int PAMX_SCHMITT_LSB = 16;
    localparam int PAMX_PINS        = 16;
    localparam int PAMX_ALTS        = 4;
    localparam int PAMX_ANALOG_PINS = 8;

    // alternate select word bit positions
    localparam int PAMX_ALT_THIRD_SPI_SECOND_SLAVE_SELECT = 2;
    localparam int PAMX_ALT_I2S_MCLK = 9;
    localparam int PAMX_ALT_EXTERNAL_BUS_ENABLE   = 11;
    localparam int PAMX_ALT_HB_LSB   = 16;
    localparam int PAMX_ALT_CAN1     = 28;

    // alternate select word one bit positions
    localparam int PAMX_A1_CARD0_CLK = 0;
    localparam int PAMX_A1_CARD0_DAT = 1;
    localparam int PAMX_A1_CARD0_PWR = 2;
    localparam int PAMX_A1_CARD0_RST = 3;
    localparam int PAMX_A1_CARD1_CLK = 5;
    localparam int PAMX_A1_CARD1_DAT = 6;
    localparam int PAMX_A1_CARD1_PWR = 7;
    localparam int PAMX_A1_CARD1_RST = 8;
    localparam int PAMX_A1_CARD2_CLK = 10;
    localparam int PAMX_A1_CARD2_DAT = 11;
    localparam int PAMX_A1_CARD2_PWR = 12;
    localparam int PAMX_A1_CARD2_RST = 13;

    // select patterns, listed msb first as in the selection tuples
    localparam logic [3:0] PAMX_PAT_ALT1    = 4'h1;
    localparam logic [3:0] PAMX_PAT_ALT2    = 4'h3;
    localparam logic [3:0] PAMX_PAT_ALT3    = 4'h5;
    localparam logic [3:0] PAMX_PAT_EBI_HB  = 4'hD;
    localparam logic [3:0] PAMX_PAT_EBI_LO  = 4'h9;

    // routing choice of one pin
    typedef enum logic [2:0] {
        PAMX_FN_GPIO,
        PAMX_FN_ALT1,
        PAMX_FN_ALT2,
        PAMX_FN_ALT3,
        PAMX_FN_ALT4
    } pamx_fn_t;

endpackage : pamx_pkg

`default_nettype wire

// [pamx_reg_word.sv]
`timescale 1ns/100ps
`default_nettype none

module pamx_reg_word (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        wr_en,
    input  wire logic [3:0]  wr_strb,
    input  wire logic [31:0] wr_data,
    output logic      [31:0] word_q
);

    typedef struct packed {
        logic [31:0] word;
    } pamx_word_st_t;

    pamx_word_st_t st_ff;
    pamx_word_st_t nxt_st;

    // byte lanes update only where the strobe is set
    always_comb begin
        nxt_st = st_ff;
        for (int b = 0; b < 4; b++) begin
            if (wr_en && wr_strb[b]) begin
                nxt_st.word[8*b +: 8] = wr_data[8*b +: 8];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '{word: pamx_pkg::PAMX_RST_WORD};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign word_q = st_ff.word;

endmodule : pamx_reg_word

`default_nettype wire

// [pamx_pin_cell.sv]
`timescale 1ns/100ps
`default_nettype none

module pamx_pin_cell (
    input  wire pamx_pkg::pamx_fn_t fn,
    input  wire logic               gpio_do,
    input  wire logic               gpio_oe,
    input  wire logic [3:0]         alt_do,
    input  wire logic [3:0]         alt_oe,
    input  wire logic               pin_in,
    output logic                    pin_do,
    output logic                    pin_oe,
    output logic                    gpio_di,
    output logic      [3:0]         alt_di
);

    // one pin: a single owner drives, only the owner sees the input
    always_comb begin
        pin_do  = gpio_do;
        pin_oe  = gpio_oe;
        gpio_di = 1'b0;
        alt_di  = 4'h0;
        unique case (fn)
            pamx_pkg::PAMX_FN_GPIO: begin
                gpio_di = pin_in;
            end
            pamx_pkg::PAMX_FN_ALT1: begin
                pin_do    = alt_do[0];
                pin_oe    = alt_oe[0];
                alt_di[0] = pin_in;
            end
            pamx_pkg::PAMX_FN_ALT2: begin
                pin_do    = alt_do[1];
                pin_oe    = alt_oe[1];
                alt_di[1] = pin_in;
            end
            pamx_pkg::PAMX_FN_ALT3: begin
                pin_do    = alt_do[2];
                pin_oe    = alt_oe[2];
                alt_di[2] = pin_in;
            end
            pamx_pkg::PAMX_FN_ALT4: begin
                pin_do    = alt_do[3];
                pin_oe    = alt_oe[3];
                alt_di[3] = pin_in;
            end
            default: begin
                gpio_di = pin_in; // unreachable code falls back to gpio
            end
        endcase
    end

endmodule : pamx_pin_cell

`default_nettype wire

// [pamx_port_a_mux.sv]
// Summary of operation
// - upper sixteen select bits each enable the schmitt input of their pin
// - pin 15: gpio, pwm3, i2s master clock, card 2 power
// - pin 14: gpio, pwm2, card 2 reset, external bus line 15
// - pin 13: gpio, pwm1, card 2 clock or uart5 tx, bus line 14
// - pin 12: gpio, pwm0, card 2 data or uart5 rx, bus line 13
// - pin 11: gpio, second i2c clock, second can receive, bus read strobe
// - pin 10: gpio, second i2c data, second can transmit, fourth function
// - pin 9: gpio or first i2c clock by its select bit
// - pin 8: gpio or first i2c data by its select bit
// - pin 7: gpio, analog 7, spi2 slave 1, card 1 data, bus line 6
// - pin 6: gpio, analog 6, card 1 clock or uart4 tx, bus line 7
// - pin 5: gpio, analog 5, card 1 reset, bus line 8
// - pin 4: gpio, analog 4, card 1 power, bus line 9
// - pin 3: gpio, analog 3, card 0 data or uart3 rx, bus line 10
// - pin 2: gpio, analog 2, card 0 clock or uart3 tx, bus line 11
// - pin 1: gpio, analog 1, card 0 reset, bus line 12
// - pin 0: gpio, analog 0, card 0 power
// - pin select word is read/write, resets to zero: all gpio, no schmitt
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module pamx_port_a_mux (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [15:0] gpio_dout,
    input  wire logic [15:0] gpio_oe,
    output logic      [15:0] gpio_din,
    input  wire logic [63:0] alt_dout,
    input  wire logic [63:0] alt_oe,
    output logic      [63:0] alt_din,
    input  wire logic [15:0] pin_in,
    output logic      [15:0] pin_out,
    output logic      [15:0] pin_oe,
    output logic      [15:0] porta_schmitt_enable,
    output logic      [7:0]  analog_enable
);

    typedef struct packed {
        pamx_pkg::pamx_fn_t [15:0] fn;
        logic [31:0]               rdata;
    } pamx_state_t;

    pamx_state_t st_ff;
    pamx_state_t nxt_st;

    logic [31:0] sel_q;
    logic [31:0] alt_q;
    logic [31:0] alt1_q;
    logic        wr_acc;
    logic        addr_hit;
    logic [15:0] not_gpio;
    logic [7:0]  hb;
    logic        ebi;
    logic [3:0]  code [16];

    // write commits only at the access edge, pready is always high
    assign wr_acc = psel && penable && pwrite;

    assign addr_hit = (paddr == pamx_pkg::PAMX_OFF_PIN_SELECT)
                   || (paddr == pamx_pkg::PAMX_OFF_ALT_WORD)
                   || (paddr == pamx_pkg::PAMX_OFF_ALT_WORD1)
                   || (paddr == pamx_pkg::PAMX_OFF_FN_STATUS);

    // the three writable words; status stays read-only
    pamx_reg_word u_pin_select (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (wr_acc && (paddr == pamx_pkg::PAMX_OFF_PIN_SELECT)),
        .wr_strb (pstrb),
        .wr_data (pwdata),
        .word_q  (sel_q)
    );

    pamx_reg_word u_alt_word (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (wr_acc && (paddr == pamx_pkg::PAMX_OFF_ALT_WORD)),
        .wr_strb (pstrb),
        .wr_data (pwdata),
        .word_q  (alt_q)
    );

    pamx_reg_word u_alt_word1 (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (wr_acc && (paddr == pamx_pkg::PAMX_OFF_ALT_WORD1)),
        .wr_strb (pstrb),
        .wr_data (pwdata),
        .word_q  (alt1_q)
    );

    assign ebi = alt_q[pamx_pkg::PAMX_ALT_EXTERNAL_BUS_ENABLE];
    assign hb  = alt_q[pamx_pkg::PAMX_ALT_HB_LSB +: 8];

    // select tuples per pin, narrow ones padded with zero at the top
    always_comb begin
        code[15] = {1'b0, alt1_q[pamx_pkg::PAMX_A1_CARD2_PWR],
                    alt_q[pamx_pkg::PAMX_ALT_I2S_MCLK], sel_q[15]};
        code[14] = {hb[7], ebi, alt1_q[pamx_pkg::PAMX_A1_CARD2_RST], sel_q[14]};
        code[13] = {hb[6], ebi, alt1_q[pamx_pkg::PAMX_A1_CARD2_CLK], sel_q[13]};
        code[12] = {hb[5], ebi, alt1_q[pamx_pkg::PAMX_A1_CARD2_DAT], sel_q[12]};
        code[11] = {1'b0, ebi, alt_q[pamx_pkg::PAMX_ALT_CAN1], sel_q[11]};
        code[10] = {1'b0, ebi, alt_q[pamx_pkg::PAMX_ALT_CAN1], sel_q[10]};
        code[9]  = {3'h0, sel_q[9]};
        code[8]  = {3'h0, sel_q[8]};
        code[7]  = {ebi, alt1_q[pamx_pkg::PAMX_A1_CARD1_DAT],
                    alt_q[pamx_pkg::PAMX_ALT_THIRD_SPI_SECOND_SLAVE_SELECT], sel_q[7]};
        code[6]  = {1'b0, ebi, alt1_q[pamx_pkg::PAMX_A1_CARD1_CLK], sel_q[6]};
        code[5]  = {hb[0], ebi, alt1_q[pamx_pkg::PAMX_A1_CARD1_RST], sel_q[5]};
        code[4]  = {hb[1], ebi, alt1_q[pamx_pkg::PAMX_A1_CARD1_PWR], sel_q[4]};
        code[3]  = {hb[2], ebi, alt1_q[pamx_pkg::PAMX_A1_CARD0_DAT], sel_q[3]};
        code[2]  = {hb[3], ebi, alt1_q[pamx_pkg::PAMX_A1_CARD0_CLK], sel_q[2]};
        code[1]  = {hb[4], ebi, alt1_q[pamx_pkg::PAMX_A1_CARD0_RST], sel_q[1]};
        code[0]  = {2'h0, alt1_q[pamx_pkg::PAMX_A1_CARD0_PWR], sel_q[0]};
    end

    // three-input family: 001, 011, 101; anything else is gpio
    function automatic pamx_pkg::pamx_fn_t dec_short(input logic [3:0] c);
        unique case (c)
            pamx_pkg::PAMX_PAT_ALT1: dec_short = pamx_pkg::PAMX_FN_ALT1;
            pamx_pkg::PAMX_PAT_ALT2: dec_short = pamx_pkg::PAMX_FN_ALT2;
            pamx_pkg::PAMX_PAT_ALT3: dec_short = pamx_pkg::PAMX_FN_ALT3;
            default:                 dec_short = pamx_pkg::PAMX_FN_GPIO;
        endcase
    endfunction : dec_short

    // bus family: the bus function needs both ebi and its high-byte bit
    function automatic pamx_pkg::pamx_fn_t dec_bus(input logic [3:0] c);
        unique case (c)
            pamx_pkg::PAMX_PAT_ALT1:   dec_bus = pamx_pkg::PAMX_FN_ALT1;
            pamx_pkg::PAMX_PAT_ALT2:   dec_bus = pamx_pkg::PAMX_FN_ALT2;
            pamx_pkg::PAMX_PAT_EBI_HB: dec_bus = pamx_pkg::PAMX_FN_ALT3;
            default:                   dec_bus = pamx_pkg::PAMX_FN_GPIO;
        endcase
    endfunction : dec_bus

    // pin 7 alone has four alternates
    function automatic pamx_pkg::pamx_fn_t dec_pin7(input logic [3:0] c);
        unique case (c)
            pamx_pkg::PAMX_PAT_ALT1:   dec_pin7 = pamx_pkg::PAMX_FN_ALT1;
            pamx_pkg::PAMX_PAT_ALT2:   dec_pin7 = pamx_pkg::PAMX_FN_ALT2;
            pamx_pkg::PAMX_PAT_ALT3:   dec_pin7 = pamx_pkg::PAMX_FN_ALT3;
            pamx_pkg::PAMX_PAT_EBI_LO: dec_pin7 = pamx_pkg::PAMX_FN_ALT4;
            default:                   dec_pin7 = pamx_pkg::PAMX_FN_GPIO;
        endcase
    endfunction : dec_pin7

    // decode is registered so that pins switch cleanly, one cycle after a write
    always_comb begin
        nxt_st        = st_ff;
        nxt_st.fn[15] = dec_short(code[15]);
        nxt_st.fn[14] = dec_bus(code[14]);
        nxt_st.fn[13] = dec_bus(code[13]);
        nxt_st.fn[12] = dec_bus(code[12]);
        nxt_st.fn[11] = dec_short(code[11]);
        nxt_st.fn[10] = dec_short(code[10]);
        nxt_st.fn[9]  = dec_short(code[9]);
        nxt_st.fn[8]  = dec_short(code[8]);
        nxt_st.fn[7]  = dec_pin7(code[7]);
        nxt_st.fn[6]  = dec_short(code[6]);
        nxt_st.fn[5]  = dec_bus(code[5]);
        nxt_st.fn[4]  = dec_bus(code[4]);
        nxt_st.fn[3]  = dec_bus(code[3]);
        nxt_st.fn[2]  = dec_bus(code[2]);
        nxt_st.fn[1]  = dec_bus(code[1]);
        nxt_st.fn[0]  = dec_short(code[0]);
        // read data latched in the setup cycle, shown in the access phase
        if (psel && !penable && !pwrite) begin
            unique case (paddr)
                pamx_pkg::PAMX_OFF_PIN_SELECT: nxt_st.rdata = sel_q;
                pamx_pkg::PAMX_OFF_ALT_WORD:   nxt_st.rdata = alt_q;
                pamx_pkg::PAMX_OFF_ALT_WORD1:  nxt_st.rdata = alt1_q;
                pamx_pkg::PAMX_OFF_FN_STATUS:  nxt_st.rdata = {8'h00, analog_enable,
                                                               not_gpio};
                default:                       nxt_st.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '{fn: '{default: pamx_pkg::PAMX_FN_GPIO}, rdata: 32'h0000_0000};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // routing per pin; alternates are packed four to a pin
    for (genvar i = 0; i < pamx_pkg::PAMX_PINS; i++) begin : g_pin
        pamx_pin_cell u_cell (
            .fn      (st_ff.fn[i]),
            .gpio_do (gpio_dout[i]),
            .gpio_oe (gpio_oe[i]),
            .alt_do  (alt_dout[4*i +: 4]),
            .alt_oe  (alt_oe[4*i +: 4]),
            .pin_in  (pin_in[i]),
            .pin_do  (pin_out[i]),
            .pin_oe  (pin_oe[i]),
            .gpio_di (gpio_din[i]),
            .alt_di  (alt_din[4*i +: 4])
        );
        assign not_gpio[i] = (st_ff.fn[i] != pamx_pkg::PAMX_FN_GPIO);
    end

    // analog pins: first alternate is the adc input, digital path must idle
    for (genvar a = 0; a < pamx_pkg::PAMX_ANALOG_PINS; a++) begin : g_ana
        assign analog_enable[a] = (st_ff.fn[a] == pamx_pkg::PAMX_FN_ALT1);
    end

    // schmitt bits straight from the stored word
    assign porta_schmitt_enable = sel_q[pamx_pkg::PAMX_SCHMITT_LSB +: 16];

    // zero-wait slave; unmapped offsets answer with an error
    assign prdata  = st_ff.rdata;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addr_hit;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic full_sel_wr;
    assign full_sel_wr = wr_acc && (paddr == pamx_pkg::PAMX_OFF_PIN_SELECT)
                      && (pstrb == 4'hF);

    schmitt_follows_a: assert property (full_sel_wr |=>
        porta_schmitt_enable == $past(pwdata[31:16]))
        else $error("schmitt enables do not follow written word");
    pin15_i2s_a: assert property (code[15] == 4'h3 |=> st_ff.fn[15] == pamx_pkg::PAMX_FN_ALT2)
        else $error("pin 15 master clock not selected");
    pin14_bus_a: assert property (code[14] == 4'hD |=> st_ff.fn[14] == pamx_pkg::PAMX_FN_ALT3)
        else $error("pin 14 bus line not selected");
    pin13_card_a: assert property (code[13] == 4'h3 |=> st_ff.fn[13] == pamx_pkg::PAMX_FN_ALT2)
        else $error("pin 13 card clock not selected");
    pin12_pwm_a: assert property (code[12] == 4'h1 |=> st_ff.fn[12] == pamx_pkg::PAMX_FN_ALT1)
        else $error("pin 12 pwm not selected");
    pin11_strobe_a: assert property (code[11] == 4'h5 |=> st_ff.fn[11] == pamx_pkg::PAMX_FN_ALT3)
        else $error("pin 11 read strobe not selected");
    pin10_can_a: assert property (code[10] == 4'h3 |=> st_ff.fn[10] == pamx_pkg::PAMX_FN_ALT2)
        else $error("pin 10 can transmit not selected");
    pin9_i2c_a: assert property (sel_q[9] |=> st_ff.fn[9] == pamx_pkg::PAMX_FN_ALT1)
        else $error("pin 9 i2c clock not selected");
    pin8_route_a: assert property (st_ff.fn[8] == pamx_pkg::PAMX_FN_ALT1 |->
        pin_out[8] == alt_dout[32] && gpio_din[8] == 1'b0)
        else $error("pin 8 not routed to i2c data");
    pin7_bus_a: assert property (code[7] == 4'h9 |=> st_ff.fn[7] == pamx_pkg::PAMX_FN_ALT4)
        else $error("pin 7 bus line not selected");
    pin6_card_a: assert property (code[6] == 4'h3 |=> st_ff.fn[6] == pamx_pkg::PAMX_FN_ALT2)
        else $error("pin 6 card clock not selected");
    pin5_adc_a: assert property (code[5] == 4'h1 |=> analog_enable[5])
        else $error("pin 5 analog input not enabled");
    pin4_bus_a: assert property (code[4] == 4'hD |=> pin_oe[4] == alt_oe[18])
        else $error("pin 4 bus line enable not routed");
    pin3_card_a: assert property (code[3] == 4'h3 |=> st_ff.fn[3] == pamx_pkg::PAMX_FN_ALT2)
        else $error("pin 3 card data not selected");
    pin2_bus_a: assert property (code[2] == 4'hD |=> st_ff.fn[2] == pamx_pkg::PAMX_FN_ALT3)
        else $error("pin 2 bus line not selected");
    pin1_reset_a: assert property (code[1] == 4'h3 |=> st_ff.fn[1] == pamx_pkg::PAMX_FN_ALT2)
        else $error("pin 1 card reset not selected");
    pin0_power_a: assert property (code[0] == 4'h3 |=> st_ff.fn[0] == pamx_pkg::PAMX_FN_ALT2)
        else $error("pin 0 card power not selected");
    sel_readback_a: assert property (psel && !penable && !pwrite
        && paddr == pamx_pkg::PAMX_OFF_PIN_SELECT |=> prdata == $past(sel_q))
        else $error("pin select word read back wrong");
    unlisted_gpio_a: assert property ((code[14] == 4'h5
        |=> st_ff.fn[14] == pamx_pkg::PAMX_FN_GPIO)
        and (code[7] == 4'h7 |=> st_ff.fn[7] == pamx_pkg::PAMX_FN_GPIO))
        else $error("unlisted select left pin off gpio");

    bus_mode_c:   cover property (code[14] == 4'hD ##1 st_ff.fn[14] == pamx_pkg::PAMX_FN_ALT3);
    pin7_spi_c:   cover property (st_ff.fn[7] == pamx_pkg::PAMX_FN_ALT2);
    bad_addr_c:   cover property (pslverr);
    schmitt_on_c: cover property (full_sel_wr ##1 porta_schmitt_enable == 16'hFFFF);

endmodule : pamx_port_a_mux

`default_nettype wire

// [port_a_pin_function_mux_bench.sv]
`timescale 1ns/100ps
`default_nettype none

module port_a_pin_function_mux_bench;
    localparam int LIMIT = 4000;

    logic        pclk;
    logic        presetn;
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [15:0] gpio_dout;
    logic [15:0] gpio_oe;
    logic [15:0] gpio_din;
    logic [63:0] alt_dout;
    logic [63:0] alt_oe;
    logic [63:0] alt_din;
    logic [15:0] pin_in;
    logic [15:0] pin_out;
    logic [15:0] pin_oe;
    logic [15:0] porta_schmitt_enable;
    logic [7:0]  analog_enable;
    int          bad_count = 0;
    int          checks_done = 0;
    int          cycles = 0;
    // per case: pin word, alternate word, alternate word one, expected alternate per pin
    logic [31:0] mfp_t [5] = '{32'h0001_FFFF, 32'h8000_FFFF, 32'hFFFF_FFFF, 32'h5A5A_FFFE,
                               32'h0000_FFFF};
    logic [31:0] alt_t [5] = '{32'h0000_0000, 32'h1000_0204, 32'h00FF_0800, 32'h10FF_0200,
                               32'h1000_0800};
    logic [31:0] a1_t  [5] = '{32'h0000_0000, 32'h0000_2DAF, 32'h0000_1000, 32'h0000_1044,
                               32'h0000_0000};
    logic [63:0] exp_t [5] = '{64'h1111_1111_1111_1111, 64'h2222_2211_2222_2222,
                               64'h4444_4411_8444_4441, 64'h0000_2211_4100_0000,
                               64'h1000_0011_8400_0001};

    pamx_port_a_mux i_pamx_port_a_mux (
        .pclk                 (pclk),
        .presetn              (presetn),
        .paddr                (paddr),
        .psel                 (psel),
        .penable              (penable),
        .pwrite               (pwrite),
        .pwdata               (pwdata),
        .pstrb                (pstrb),
        .prdata               (prdata),
        .pready               (pready),
        .pslverr              (pslverr),
        .gpio_dout            (gpio_dout),
        .gpio_oe              (gpio_oe),
        .gpio_din             (gpio_din),
        .alt_dout             (alt_dout),
        .alt_oe               (alt_oe),
        .alt_din              (alt_din),
        .pin_in               (pin_in),
        .pin_out              (pin_out),
        .pin_oe               (pin_oe),
        .porta_schmitt_enable (porta_schmitt_enable),
        .analog_enable        (analog_enable)
    );

    // free-running clock, 5 ns period
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out

    // hang guard, generous against about a hundred cycles of traffic
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            bad_count++;
            close_out();
        end
    end

    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // one apb transfer; holds the request until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
                       input logic [3:0] strb, output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wd;
        pstrb   <= strb;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // expected pad routing from the selected alternate of each pin (nibble one-hot)
    task automatic check_pins(input logic [63:0] nib);
        logic [15:0] eg;
        logic [15:0] eo;
        logic [15:0] eoe;
        logic [7:0]  ea;
        @(negedge pclk);
        for (int i = 0; i < 16; i++) begin
            eg[i]  = (nib[4*i+:4] == 4'h0);
            eo[i]  = !eg[i] | gpio_dout[i];
            eoe[i] = !eg[i] | gpio_oe[i];
            if (i < 8) ea[i] = (nib[4*i+:4] == 4'h1);
        end
        chk("alt_din", nib, alt_din);
        chk("gpio_din", eg, gpio_din);
        chk("pin_out", eo, pin_out);
        chk("pin_oe", eoe, pin_oe);
        chk("analog_enable", ea, analog_enable);
    endtask : check_pins

    // main sequence: reset values, every documented routing, refusals, mid-run reset
    initial begin
        logic [31:0] rd;
        logic        err;
        presetn   = 1'b0;
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        paddr     = 12'h000;
        pwdata    = 32'h0000_0000;
        pstrb     = 4'hF;
        gpio_dout = 16'h5A5A;
        gpio_oe   = 16'hA5A5;
        alt_dout  = {64{1'b1}};
        alt_oe    = {64{1'b1}};
        pin_in    = 16'hFFFF;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, pamx_pkg::PAMX_OFF_PIN_SELECT, 32'h0, 4'hF, rd, err);
        chk("word after reset", 32'h0000_0000, rd);
        check_pins(64'h0);
        for (int k = 0; k < 5; k++) begin
            apb(1'b1, pamx_pkg::PAMX_OFF_PIN_SELECT, mfp_t[k], 4'hF, rd, err);
            apb(1'b1, pamx_pkg::PAMX_OFF_ALT_WORD, alt_t[k], 4'hF, rd, err);
            apb(1'b1, pamx_pkg::PAMX_OFF_ALT_WORD1, a1_t[k], 4'hF, rd, err);
            apb(1'b0, pamx_pkg::PAMX_OFF_PIN_SELECT, 32'h0, 4'hF, rd, err);
            chk("word readback", mfp_t[k], rd);
            check_pins(exp_t[k]);
            chk("schmitt", mfp_t[k][31:16], porta_schmitt_enable);
        end
        // status word after the last case; writes to it are dropped quietly
        apb(1'b1, pamx_pkg::PAMX_OFF_FN_STATUS, 32'hFFFF_FFFF, 4'hF, rd, err);
        chk("status write err", 1'b0, err);
        apb(1'b0, pamx_pkg::PAMX_OFF_FN_STATUS, 32'h0, 4'hF, rd, err);
        chk("status word", 32'h0001_83C1, rd);
        // partial byte write touches only the strobed byte
        apb(1'b1, pamx_pkg::PAMX_OFF_PIN_SELECT, 32'hFFFF_FFFF, 4'h4, rd, err);
        apb(1'b0, pamx_pkg::PAMX_OFF_PIN_SELECT, 32'h0, 4'hF, rd, err);
        chk("strobed word", 32'h00FF_FFFF, rd);
        chk("strobed schmitt", 16'h00FF, porta_schmitt_enable);
        // unmapped place: error response, nothing stored
        apb(1'b1, 12'h0FC, 32'hFFFF_FFFF, 4'hF, rd, err);
        chk("unmapped write err", 1'b1, err);
        apb(1'b0, 12'h0FC, 32'h0, 4'hF, rd, err);
        chk("unmapped read err", 1'b1, err);
        chk("unmapped read data", 32'h0, rd);
        // reset in mid-run returns every pin to gpio with schmitt off
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        check_pins(64'h0);
        chk("schmitt in reset", 16'h0000, porta_schmitt_enable);
        @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, pamx_pkg::PAMX_OFF_PIN_SELECT, 32'h0, 4'hF, rd, err);
        chk("word after second reset", 32'h0000_0000, rd);
        close_out();
    end
endmodule : port_a_pin_function_mux_bench

`default_nettype wire
